// ==== dpc_defines.svh ====
// Constants for the synthesis pin control block.
// Assumes inclusion by bare name from the package and the design file.
`ifndef DPC_DEFINES_SVH
`define DPC_DEFINES_SVH
`define DPC_ACC_W 28
`define DPC_PHASE_W 12
`define DPC_WORD_W 16
`define DPC_BITCNT_W 5
`define DPC_BITS_PER_WORD 5'h10
`define DPC_ADDR_W 3
`define DPC_ADDR_FREQ_A 3'h0
`define DPC_ADDR_FREQ_B 3'h1
`define DPC_ADDR_PHASE_A 3'h2
`define DPC_ADDR_PHASE_B 3'h3
`define DPC_ADDR_CTRL 3'h4
`define DPC_ADDR_STATUS 3'h5
`define DPC_ADDR_LAST_WORD 3'h6
`define DPC_CTRL_FREQ_SEL 0
`define DPC_CTRL_PHASE_SEL 1
`define DPC_CTRL_FREQ_SRC 2
`define DPC_CTRL_PHASE_SRC 3
`define DPC_CTRL_POWERDOWN 4
`define DPC_CTRL_LOUT_EN 5
`define DPC_CTRL_LOUT_SRC 6
`define DPC_CTRL_RESET 7'h00
`define DPC_FREQ_RESET 28'h0000000
`define DPC_PHASE_RESET 12'h000
`endif

// ==== dpc_pkg.sv ====
// Types for the synthesis pin control block.
// Assumes dpc_defines.svh is on the include path.
`include "dpc_defines.svh"
package dpc_pkg;
  typedef enum logic [1:0] {
    DPC_IDLE = 2'b01,
    DPC_SHIFT = 2'b10
  } dpc_ser_state_t;

  typedef struct packed {
    logic freq_select_bit;
    logic phase_select_bit;
    logic freq_src_bit;
    logic phase_src_bit;
    logic dac_powerdown_bit;
    logic logic_out_enable;
    logic logic_out_source_sel;
  } dpc_ctrl_t;

  typedef struct packed {
    logic [`DPC_ACC_W-1:0] freq_word_a;
    logic [`DPC_ACC_W-1:0] freq_word_b;
    logic [`DPC_PHASE_W-1:0] phase_offset_a;
    logic [`DPC_PHASE_W-1:0] phase_offset_b;
    dpc_ctrl_t ctrl;
  } dpc_regs_t;

  typedef struct packed {
    logic [1:0] sclk_sync;
    logic [1:0] frame_sync_n_sync;
    logic [1:0] serial_data_in_sync;
    logic [1:0] freq_select_bit_sync;
    logic [1:0] psel_sync;
    logic [1:0] rst_sync;
    logic [1:0] sleep_sync;
    logic [1:0] vin_sync;
    logic sclk_prev;
  } dpc_sync_t;
endpackage : dpc_pkg

// ==== dpc_core.sv ====
// Pin control logic of a direct digital synthesis generator.
// Assumes the serial, select, reset, sleep and comparator pins are asynchronous to sys_clk and that sys_clk is the master clock.
// Summary of operation
// (RQ1) Master clock alone times the datapath.
// (RQ2) Frequency select chooses word a or b.
// (RQ3) Host holds pin fixed when bit selects.
// (RQ4) Phase select chooses offset a or b.
// (RQ5) Host holds phase pin fixed when bit selects.
// (RQ6) Reset input clears accumulator, output midscale.
// (RQ7) Reset input leaves addressable registers alone.
// (RQ8) Sleep input high powers down converter.
// (RQ9) Sleep input equals power-down control bit.
// (RQ10) Each serial transfer carries one 16-bit word.
// (RQ11) Sample serial data on clock falling edges.
// (RQ12) Frame sync low starts a fresh word.
// (RQ13) Logic output driven only when enabled.
// (RQ14) Source select picks comparator or accumulator MSB.
// (RQ15) Enabled comparator source routes comparator input.
// (RQ16) 28-bit accumulator adds word, wraps.
// (RQ17) 12-bit offset added to accumulator MSBs.
// (RQ18) Sine phase is upper 12 bits.
// (RQ19) MSB first, complete after sixteenth edge.
// (RQ20) Select pins sampled on master clock.
//
// Local design decisions: the register addresses and the plain strobed port.
`timescale 1ns/1ps
`include "dpc_defines.svh"
module dpc_core (
  // Master clock and its reset.
  input wire logic sys_clk,
  input wire logic rst_n,
  // Serial link pins, asynchronous to sys_clk.
  input wire logic serial_clk,
  input wire logic serial_data_in,
  input wire logic frame_sync_n,
  // Select, datapath reset, sleep and comparator pins.
  input wire logic freq_select_pin,
  input wire logic phase_select_pin,
  input wire logic dp_reset,
  input wire logic sleep,
  input wire logic comparator_input,
  // Register port on sys_clk.
  input wire logic [`DPC_ADDR_W-1:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  // Received word and datapath outputs.
  output logic [`DPC_WORD_W-1:0] serial_word,
  output logic serial_word_valid,
  output logic [`DPC_PHASE_W-1:0] sine_phase,
  output logic dac_powerdown,
  output logic square_logic_out,
  output logic square_logic_out_oe_n
);

  // ==========================================================================
  // State
  // ==========================================================================
  typedef struct packed {
    dpc_pkg::dpc_sync_t sync;
    dpc_pkg::dpc_regs_t regs;
    dpc_pkg::dpc_ser_state_t ser_state;
    logic [`DPC_WORD_W-1:0] shift;
    logic [`DPC_BITCNT_W-1:0] bit_cnt;
    logic [`DPC_WORD_W-1:0] word;
    logic word_valid;
    logic word_seen;
    logic [`DPC_ACC_W-1:0] acc;
    logic [`DPC_PHASE_W-1:0] phase;
    logic pd;
    logic lout;
    logic lout_oe_n;
    logic [31:0] rdata;
  } dpc_state_t;

  dpc_state_t st_q;
  dpc_state_t st_d;

  logic freq_select_bit_eff;
  logic psel_eff;
  logic [`DPC_ACC_W-1:0] step;
  logic [`DPC_PHASE_W-1:0] offset;
  logic sclk_fall;
  logic dp_clear;

  // ==========================================================================
  // Datapath selection
  // ==========================================================================
  always_comb begin
    // The control bit overrides the pin only when its source bit is set.
    freq_select_bit_eff = st_q.regs.ctrl.freq_src_bit ? st_q.regs.ctrl.freq_select_bit : st_q.sync.freq_select_bit_sync[1]; // RQ3 RQ20
    psel_eff = st_q.regs.ctrl.phase_src_bit ? st_q.regs.ctrl.phase_select_bit : st_q.sync.psel_sync[1]; // RQ5 RQ20
    step = freq_select_bit_eff ? st_q.regs.freq_word_b : st_q.regs.freq_word_a; // RQ2
    offset = psel_eff ? st_q.regs.phase_offset_b : st_q.regs.phase_offset_a; // RQ4
    sclk_fall = st_q.sync.sclk_prev & ~st_q.sync.sclk_sync[1]; // RQ11
    dp_clear = st_q.sync.rst_sync[1];
  end

  // ==========================================================================
  // Next state
  // ==========================================================================
  always_comb begin
    st_d = st_q;

    // ========================================================================
    // Pin synchronisers
    // ========================================================================
    // Only the second stage is read anywhere, so a metastable first stage
    // never reaches the receiver or the datapath.
    st_d.sync.sclk_sync = {st_q.sync.sclk_sync[0], serial_clk};
    st_d.sync.frame_sync_n_sync = {st_q.sync.frame_sync_n_sync[0], frame_sync_n};
    st_d.sync.serial_data_in_sync = {st_q.sync.serial_data_in_sync[0], serial_data_in};
    st_d.sync.freq_select_bit_sync = {st_q.sync.freq_select_bit_sync[0], freq_select_pin};
    st_d.sync.psel_sync = {st_q.sync.psel_sync[0], phase_select_pin};
    st_d.sync.rst_sync = {st_q.sync.rst_sync[0], dp_reset};
    st_d.sync.sleep_sync = {st_q.sync.sleep_sync[0], sleep};
    st_d.sync.vin_sync = {st_q.sync.vin_sync[0], comparator_input};
    st_d.sync.sclk_prev = st_q.sync.sclk_sync[1];
    st_d.word_valid = 1'b0;

    // ========================================================================
    // Serial receiver
    // ========================================================================
    // The data is sampled a few master cycles after the
    // falling edge, so the serial clock must be slow relative to sys_clk.
    case (st_q.ser_state)
      dpc_pkg::DPC_IDLE: begin
        if (!st_q.sync.frame_sync_n_sync[1]) begin
          st_d.ser_state = dpc_pkg::DPC_SHIFT; // RQ12
          st_d.bit_cnt = '0;
        end
      end
      dpc_pkg::DPC_SHIFT: begin
        if (st_q.sync.frame_sync_n_sync[1]) begin
          // Frame ended early: a partial word is dropped.
          st_d.ser_state = dpc_pkg::DPC_IDLE;
        end else if (sclk_fall && st_q.bit_cnt != `DPC_BITS_PER_WORD) begin
          st_d.shift = {st_q.shift[`DPC_WORD_W-2:0], st_q.sync.serial_data_in_sync[1]}; // RQ19
          st_d.bit_cnt = st_q.bit_cnt + 5'h01;
          if (st_q.bit_cnt == `DPC_BITS_PER_WORD - 5'h01) begin
            st_d.word = {st_q.shift[`DPC_WORD_W-2:0], st_q.sync.serial_data_in_sync[1]}; // RQ10
            st_d.word_valid = 1'b1;
            st_d.word_seen = 1'b1;
          end
        end
      end
      default: begin
        st_d.ser_state = dpc_pkg::DPC_IDLE;
      end
    endcase

    // ========================================================================
    // Register writes
    // ========================================================================
    // The datapath reset input never touches these.
    if (reg_wr) begin // RQ7
      case (reg_addr)
        `DPC_ADDR_FREQ_A: st_d.regs.freq_word_a = reg_wdata[`DPC_ACC_W-1:0];
        `DPC_ADDR_FREQ_B: st_d.regs.freq_word_b = reg_wdata[`DPC_ACC_W-1:0];
        `DPC_ADDR_PHASE_A: st_d.regs.phase_offset_a = reg_wdata[`DPC_PHASE_W-1:0];
        `DPC_ADDR_PHASE_B: st_d.regs.phase_offset_b = reg_wdata[`DPC_PHASE_W-1:0];
        `DPC_ADDR_CTRL: begin
          st_d.regs.ctrl.freq_select_bit = reg_wdata[`DPC_CTRL_FREQ_SEL];
          st_d.regs.ctrl.phase_select_bit = reg_wdata[`DPC_CTRL_PHASE_SEL];
          st_d.regs.ctrl.freq_src_bit = reg_wdata[`DPC_CTRL_FREQ_SRC];
          st_d.regs.ctrl.phase_src_bit = reg_wdata[`DPC_CTRL_PHASE_SRC];
          st_d.regs.ctrl.dac_powerdown_bit = reg_wdata[`DPC_CTRL_POWERDOWN];
          st_d.regs.ctrl.logic_out_enable = reg_wdata[`DPC_CTRL_LOUT_EN];
          st_d.regs.ctrl.logic_out_source_sel = reg_wdata[`DPC_CTRL_LOUT_SRC];
        end
        default: begin
        end
      endcase
    end

    // ========================================================================
    // Read-back
    // ========================================================================
    // Read data stands only in the cycle after the strobe.
    st_d.rdata = 32'h0000_0000;
    if (reg_rd) begin
      case (reg_addr)
        `DPC_ADDR_FREQ_A: st_d.rdata[`DPC_ACC_W-1:0] = st_q.regs.freq_word_a;
        `DPC_ADDR_FREQ_B: st_d.rdata[`DPC_ACC_W-1:0] = st_q.regs.freq_word_b;
        `DPC_ADDR_PHASE_A: st_d.rdata[`DPC_PHASE_W-1:0] = st_q.regs.phase_offset_a;
        `DPC_ADDR_PHASE_B: st_d.rdata[`DPC_PHASE_W-1:0] = st_q.regs.phase_offset_b;
        `DPC_ADDR_CTRL: begin
          st_d.rdata[`DPC_CTRL_FREQ_SEL] = st_q.regs.ctrl.freq_select_bit;
          st_d.rdata[`DPC_CTRL_PHASE_SEL] = st_q.regs.ctrl.phase_select_bit;
          st_d.rdata[`DPC_CTRL_FREQ_SRC] = st_q.regs.ctrl.freq_src_bit;
          st_d.rdata[`DPC_CTRL_PHASE_SRC] = st_q.regs.ctrl.phase_src_bit;
          st_d.rdata[`DPC_CTRL_POWERDOWN] = st_q.regs.ctrl.dac_powerdown_bit;
          st_d.rdata[`DPC_CTRL_LOUT_EN] = st_q.regs.ctrl.logic_out_enable;
          st_d.rdata[`DPC_CTRL_LOUT_SRC] = st_q.regs.ctrl.logic_out_source_sel;
        end
        // Status samples live state; a write to its index is ignored.
        `DPC_ADDR_STATUS: begin
          st_d.rdata[0] = freq_select_bit_eff;
          st_d.rdata[1] = psel_eff;
          st_d.rdata[2] = dp_clear;
          st_d.rdata[3] = st_q.pd;
          st_d.rdata[4] = st_q.word_seen;
        end
        `DPC_ADDR_LAST_WORD: st_d.rdata[`DPC_WORD_W-1:0] = st_q.word;
        default: st_d.rdata = 32'h0000_0000;
      endcase
    end

    // ========================================================================
    // Phase datapath
    // ========================================================================
    // Phase accumulator and offset adder, both on sys_clk only.
    // The adder reads last cycle's accumulator, so sine_phase trails acc by
    // one clock; both clear together, so the pair never disagrees on reset.
    if (dp_clear) begin
      st_d.acc = '0; // RQ6
      st_d.phase = '0; // RQ6
    end else begin
      st_d.acc = st_q.acc + step; // RQ1 RQ16
      st_d.phase = st_q.acc[`DPC_ACC_W-1 -: `DPC_PHASE_W] + offset; // RQ17 RQ18
    end

    // ========================================================================
    // Converter and logic output
    // ========================================================================
    // Either source powers the converter down; neither can keep it up
    // against the other.
    st_d.pd = st_q.sync.sleep_sync[1] | st_q.regs.ctrl.dac_powerdown_bit; // RQ8 RQ9
    // A disabled output keeps following the accumulator MSB, so enabling it
    // never shows a stale comparator level.
    st_d.lout_oe_n = ~st_q.regs.ctrl.logic_out_enable; // RQ13
    if (st_q.regs.ctrl.logic_out_enable && st_q.regs.ctrl.logic_out_source_sel) begin
      st_d.lout = st_q.sync.vin_sync[1]; // RQ14 RQ15
    end else begin
      st_d.lout = st_q.acc[`DPC_ACC_W-1]; // RQ14
    end
  end

  // ==========================================================================
  // Registers
  // ==========================================================================
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_q <= '0;
      // Synchronisers of idle-high pins reset high, so the release of reset
      // shows no false serial clock edge or frame start.
      st_q.sync.sclk_sync <= 2'h3;
      st_q.sync.frame_sync_n_sync <= 2'h3;
      st_q.sync.sclk_prev <= 1'b1;
      st_q.ser_state <= dpc_pkg::DPC_IDLE;
      st_q.regs.freq_word_a <= `DPC_FREQ_RESET;
      st_q.regs.freq_word_b <= `DPC_FREQ_RESET;
      st_q.regs.phase_offset_a <= `DPC_PHASE_RESET;
      st_q.regs.phase_offset_b <= `DPC_PHASE_RESET;
      st_q.regs.ctrl <= `DPC_CTRL_RESET;
      st_q.lout_oe_n <= 1'b1;
    end else begin
      st_q <= st_d;
    end
  end

  assign reg_rdata = st_q.rdata;
  assign serial_word = st_q.word;
  assign serial_word_valid = st_q.word_valid;
  assign sine_phase = st_q.phase;
  assign dac_powerdown = st_q.pd;
  assign square_logic_out = st_q.lout;
  assign square_logic_out_oe_n = st_q.lout_oe_n;

endmodule : dpc_core

// ==== dpc_core_properties.sv ====
// Concurrent checks on the ports of dpc_core.
// Assumes the bind at the foot reaches every dpc_core instance.
`timescale 1ns/1ps
module dpc_core_properties (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic dp_reset,
  input wire logic sleep,
  input wire logic comparator_input,
  input wire logic [2:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [31:0] reg_rdata,
  input wire logic [15:0] serial_word,
  input wire logic serial_word_valid,
  input wire logic [11:0] sine_phase,
  input wire logic dac_powerdown,
  input wire logic square_logic_out,
  input wire logic square_logic_out_oe_n
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  // ======
  // Shadow of the logic output bits, taken from the bus writes.
  logic en_q, src_q;
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      en_q <= 1'b0;
      src_q <= 1'b0;
    end else if (reg_wr && reg_addr == 3'h4) begin
      en_q <= reg_wdata[5];
      src_q <= reg_wdata[6];
    end
  end
  sequence cmp_held;
    (en_q && src_q && $stable(comparator_input))[*5];
  endsequence
  // ======
  rdata_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
    else $error("read data outside its slot");
  unmapped_rd_a: assert property (reg_rd && reg_addr == 3'h7 |=> reg_rdata == 32'h0)
    else $error("unmapped read not zero");
  valid_gap_a: assert property (serial_word_valid |=> !serial_word_valid[*8])
    else $error("word valid too close");
  word_change_a: assert property ($changed(serial_word) |-> ##[0:1] (serial_word_valid || $past(serial_word_valid)))
    else $error("word changed without valid");
  dp_clear_a: assert property (dp_reset[*5] |-> sine_phase == 12'h0)
    else $error("phase not cleared");
  sleep_pd_a: assert property (sleep[*5] |-> dac_powerdown)
    else $error("sleep ignored");
  oe_ctrl_a: assert property (en_q == $past(en_q, 3) |-> square_logic_out_oe_n == !en_q)
    else $error("output enable wrong");
  cmp_route_a: assert property (cmp_held |-> square_logic_out == comparator_input)
    else $error("comparator not routed");
endmodule : dpc_core_properties
bind dpc_core dpc_core_properties chk_u (
  .sys_clk, .rst_n, .dp_reset, .sleep, .comparator_input,
  .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
  .serial_word, .serial_word_valid, .sine_phase,
  .dac_powerdown, .square_logic_out, .square_logic_out_oe_n
);

// ==== dpc_host_model.sv ====
// Host side of the serial link, framing 16-bit words.
// Assumes the bench calls send through the instance path.
`timescale 1ns/1ps
module dpc_host_model (
  output logic serial_clk,
  output logic serial_data_in,
  output logic frame_sync_n
);
  // The clock idles high and only toggles inside a frame.
  initial begin
    serial_clk = 1'b1;
    serial_data_in = 1'b0;
    frame_sync_n = 1'b1;
  end
  // Sends the top n bits of w; fewer than 16 aborts the frame.
  task automatic send(input logic [15:0] w, input int n);
    // The odd start delay keeps every pin change clear of a sys_clk edge when send starts on one.
    #210 frame_sync_n = 1'b0;
    for (int i = 15; i > 15 - n; i--) begin
      serial_data_in = w[i];
      #160 serial_clk = 1'b0;
      #160 serial_clk = 1'b1;
    end
    #160 frame_sync_n = 1'b1;
    serial_data_in = ~serial_data_in;
  endtask : send
endmodule : dpc_host_model

// ==== dpc_core_tb_top.sv ====
// Self-checking bench for dpc_core.
// Assumes the checker and the host model are compiled first.
`timescale 1ns/1ps
module dpc_core_tb_top;
  logic sys_clk = 1'b0, rst_n = 1'b0, dp_reset = 1'b0, sleep = 1'b0;
  logic comparator_input = 1'b0, freq_select_pin = 1'b0, phase_select_pin = 1'b0;
  logic reg_wr = 1'b0, reg_rd = 1'b0;
  logic [2:0] reg_addr = 3'h0;
  logic [31:0] reg_wdata = 32'h0, reg_rdata, rd_v;
  logic [15:0] serial_word;
  logic [11:0] sine_phase, ph0;
  logic serial_clk, serial_data_in, frame_sync_n, serial_word_valid;
  logic dac_powerdown, square_logic_out, square_logic_out_oe_n;
  int err_total = 0, compares = 0, cycles = 0, vcnt = 0, v0, n;
  always #20 sys_clk = ~sys_clk;
  dpc_host_model host_u (.serial_clk, .serial_data_in, .frame_sync_n);
  dpc_core dut_u (.sys_clk, .rst_n, .serial_clk, .serial_data_in, .frame_sync_n,
    .freq_select_pin, .phase_select_pin, .dp_reset, .sleep, .comparator_input,
    .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .serial_word,
    .serial_word_valid, .sine_phase, .dac_powerdown, .square_logic_out,
    .square_logic_out_oe_n);
  // ======
  // A hang is cut short well after the longest expected run.
  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (serial_word_valid === 1'b1) vcnt <= vcnt + 1;
    if (cycles == 5000) begin
      err_total++;
      test_done();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      err_total++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [2:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    {reg_wr, reg_addr, reg_wdata} <= {1'b1, a, d};
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [2:0] a);
    @(posedge sys_clk);
    {reg_rd, reg_addr} <= {1'b1, a};
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1 rd_v = reg_rdata;
  endtask : rd
  task automatic cyc(input int k);
    repeat (k) @(posedge sys_clk);
    #1;
  endtask : cyc
  // ======
  task automatic t_regs;
    wr(3'h0, 32'hf001_0000);
    wr(3'h1, 32'h0);
    wr(3'h3, 32'hffff_f123);
    rd(3'h0);
    chk(rd_v, 32'h0010000);
    rd(3'h3);
    chk(rd_v, 32'h123);
    rd(3'h7);
    chk(rd_v, 32'h0);
  endtask : t_regs
  task automatic t_dp;
    @(posedge sys_clk) freq_select_pin <= 1'b1;
    dp_reset <= 1'b1;
    cyc(6);
    chk(sine_phase, 12'h0);
    rd(3'h3);
    chk(rd_v, 32'h123);
    @(posedge sys_clk) dp_reset <= 1'b0;
    cyc(6);
    chk(sine_phase, 12'h0);
    @(posedge sys_clk) phase_select_pin <= 1'b1;
    cyc(6);
    chk(sine_phase, 12'h123);
    @(posedge sys_clk) freq_select_pin <= 1'b0;
    cyc(6);
    ph0 = sine_phase + 12'h1;
    cyc(1);
    chk(sine_phase, ph0);
    wr(3'h4, 32'h5);
    cyc(6);
    ph0 = sine_phase;
    cyc(1);
    chk(sine_phase, ph0);
    wr(3'h4, 32'hd);
    cyc(6);
    ph0 = ph0 - 12'h123;
    chk(sine_phase, ph0);
    wr(3'h4, 32'h0);
  endtask : t_dp
  task automatic t_ser;
    v0 = vcnt;
    host_u.send(16'h5aa5, 8);
    host_u.send(16'ha5c3, 16);
    for (n = 0; n < 100 && vcnt == v0; n++) cyc(1);
    cyc(4);
    chk(vcnt - v0, 32'h1);
    chk(serial_word, 16'ha5c3);
    rd(3'h6);
    chk(rd_v, 32'ha5c3);
    rd(3'h5);
    chk(rd_v, 32'h12);
  endtask : t_ser
  task automatic t_out;
    wr(3'h4, 32'h60);
    rd(3'h4);
    chk(rd_v, 32'h60);
    @(posedge sys_clk) comparator_input <= 1'b1;
    cyc(6);
    chk({square_logic_out_oe_n, square_logic_out}, 2'b01);
    @(posedge sys_clk) comparator_input <= 1'b0;
    cyc(6);
    chk(square_logic_out, 1'b0);
    // Word b of half the range flips the accumulator MSB on every clock.
    wr(3'h1, 32'h0800_0000);
    wr(3'h4, 32'h25);
    cyc(4);
    ph0 = {11'h000, square_logic_out};
    cyc(1);
    chk(square_logic_out, ph0 ^ 12'h001);
    wr(3'h4, 32'h10);
    cyc(4);
    chk({square_logic_out_oe_n, dac_powerdown}, 2'b11);
    wr(3'h4, 32'h0);
    @(posedge sys_clk) sleep <= 1'b1;
    cyc(6);
    chk(dac_powerdown, 1'b1);
    @(posedge sys_clk) sleep <= 1'b0;
    cyc(6);
    chk(dac_powerdown, 1'b0);
  endtask : t_out
  task automatic test_done;
    $display("compares %0d err_total %0d", compares, err_total);
    if (err_total == 0 && compares > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : test_done
  initial begin
    repeat (8) @(posedge sys_clk);
    rst_n <= 1'b1;
    t_regs();
    t_dp();
    t_ser();
    t_out();
    test_done();
  end
endmodule : dpc_core_tb_top
